// ==== verilog/aux_output_sequencer.sv ====
// Sequenced auxiliary outputs with delay and drive registers
// Operation
// R1: Shutdown delay is upper nibble times step
// R2: Startup delay is lower nibble times step
// R3: Long range makes each step 1 ms
// R4: Second output has its own delay register
// R5: Third output has its own delay register
// R6: First output gated by selected enable pin
// R7: Second output gated by selected enable pin
// R8: Bit 0 sets first output level
// R9: Bit 4 level acts only in output mode
// R10: Bit 3 selects first output open drain
// R11: Bit 7 selects shared pin open drain
// R12: Fields load defaults at init, stay writable
// R13: Shutdown range select picks shutdown step
// R14: Function select picks power good or output
// R15: Control returning early cancels the timer
// R16: Shutdown delays use the shutdown range select
`timescale 1ns/100ps
module aux_output_sequencer
    import aux_seq_pkg::*;
#(
    parameter int STEP_CYCLES = HALF_MS_CYCLES // Cycles per 0.5 ms
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [7:0] otp_delays_a,
    input wire logic [7:0] otp_delays_b,
    input wire logic [7:0] otp_delays_c,
    input wire logic [7:0] otp_drive_control,
    input wire logic startup_range_sel,
    input wire logic shutdown_range_sel,
    input wire logic shared_pin_func_sel,
    input wire logic power_good_one,
    input wire logic aux_c_ctrl,
    input wire logic enable_pin_one,
    input wire logic enable_pin_two,
    input wire logic enable_pin_three,
    input wire logic aux_output_a_i,
    output logic aux_output_a_o,
    output logic aux_output_a_oe_n,
    input wire logic aux_output_b_i,
    output logic aux_output_b_o,
    output logic aux_output_b_oe_n,
    output logic aux_output_c,
    output logic [1:0] pad_level
);
    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] delays_r [3];     // Delay registers, one per output
    logic [7:0] drive_r;          // Level, gate and drive bits
    logic init_done_r;            // Defaults already loaded
    logic [4:0] sync1_r;          // First synchroniser stage
    logic [4:0] sync2_r;          // Second synchroniser stage
    logic [2:0] en_sync;          // Enable pins in clock domain
    logic ctrl_a;                 // Control of the first output
    logic ctrl_b;                 // Control of the second output
    logic [7:0] rdata_nxt;        // Read data before registering
    logic [2:0] level;            // Delayed levels from timers
    logic a_drv_o_r;              // Registered pin drive, first
    logic a_drv_oe_n_r;
    logic b_drv_o_r;              // Registered pin drive, second
    logic b_drv_oe_n_r;
    logic c_out_r;                // Registered third output
    logic [7:0] rdata_r;
    logic rvalid_r;
    seq_if sif [3] ();

    // Gate a level bit with the enable pin that a code selects
    function automatic logic gate_fn(input logic lvl,
                                     input logic [1:0] sel,
                                     input logic [2:0] en);
        case (sel)
            GATE_NONE: gate_fn = lvl;
            GATE_PIN_ONE: gate_fn = lvl & en[0];
            GATE_PIN_TWO: gate_fn = lvl & en[1];
            GATE_PIN_THREE: gate_fn = lvl & en[2];
            default: gate_fn = 1'b0;
        endcase
    endfunction : gate_fn

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Two flip-flops before any logic sees a pin
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {aux_output_b_i, aux_output_a_i, enable_pin_three,
                        enable_pin_two, enable_pin_one};
            sync2_r <= sync1_r;
        end
    end

    assign en_sync = sync2_r[2:0];
    assign pad_level = sync2_r[4:3];

    // ************************************************************
    // Register file
    // ************************************************************
    // Reset constants, then defaults from OTP once, then writes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            delays_r[0] <= DELAYS_RESET;
            delays_r[1] <= DELAYS_RESET;
            delays_r[2] <= DELAYS_RESET;
            drive_r <= DRIVE_CONTROL_RESET;
            init_done_r <= 1'b0;
        end else if (!init_done_r) begin
            delays_r[0] <= otp_delays_a; // see R12
            delays_r[1] <= otp_delays_b;
            delays_r[2] <= otp_delays_c;
            drive_r <= otp_drive_control;
            init_done_r <= 1'b1;
        end else if (reg_we) begin
            // Each delay register stands alone
            case (reg_addr)
                OUT0_SEQUENCE_DELAYS_OFS: delays_r[0] <= reg_wdata;
                OUT1_SEQUENCE_DELAYS_OFS: delays_r[1] <= reg_wdata; // see R4
                OUT2_SEQUENCE_DELAYS_OFS: delays_r[2] <= reg_wdata; // see R5
                OUT01_DRIVE_CONTROL_OFS: drive_r <= reg_wdata;
                default: ; // Unmapped writes are dropped
            endcase
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        case (reg_addr)
            OUT0_SEQUENCE_DELAYS_OFS: rdata_nxt = delays_r[0];
            OUT1_SEQUENCE_DELAYS_OFS: rdata_nxt = delays_r[1];
            OUT2_SEQUENCE_DELAYS_OFS: rdata_nxt = delays_r[2];
            OUT01_DRIVE_CONTROL_OFS: rdata_nxt = drive_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data is held until the next read
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_re;
            if (reg_re) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;

    // ************************************************************
    // Control signals and timers
    // ************************************************************
    assign ctrl_a = gate_fn(drive_r[OUT_A_LEVEL_BIT],
                            drive_r[OUT_A_GATE_MSB:OUT_A_GATE_LSB],
                            en_sync); // see R6 see R8
    assign ctrl_b = gate_fn(drive_r[OUT_B_LEVEL_BIT],
                            drive_r[OUT_B_GATE_MSB:OUT_B_GATE_LSB],
                            en_sync); // see R7

    // One timer per output, each with its own delay register
    for (genvar i = 0; i < 3; i++) begin : g_timer
        assign sif[i].ctrl = (i == 0) ? ctrl_a :
                             (i == 1) ? ctrl_b : aux_c_ctrl;
        assign sif[i].on_code = delays_r[i][ON_DELAY_MSB:ON_DELAY_LSB];
        assign sif[i].off_code = delays_r[i][OFF_DELAY_MSB:OFF_DELAY_LSB];
        assign sif[i].on_long = startup_range_sel; // see R3
        assign sif[i].off_long = shutdown_range_sel; // see R13 see R16
        assign level[i] = sif[i].level;
        seq_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
            .clk(clk),
            .nrst(nrst),
            .sif(sif[i])
        );
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // Push-pull drives always; open drain releases the high level
    always_ff @(posedge clk) begin
        if (!nrst) begin
            a_drv_o_r <= 1'b0;
            a_drv_oe_n_r <= 1'b1;
        end else begin
            a_drv_o_r <= level[0];
            a_drv_oe_n_r <= drive_r[OUT_A_DRAIN_BIT] & level[0]; // see R10
        end
    end

    // Shared pin carries power good or the second output
    always_ff @(posedge clk) begin
        if (!nrst) begin
            b_drv_o_r <= 1'b0;
            b_drv_oe_n_r <= 1'b1;
        end else if (shared_pin_func_sel) begin
            b_drv_o_r <= level[1]; // see R9 see R14
            b_drv_oe_n_r <= drive_r[OUT_B_DRAIN_BIT] & level[1]; // see R11
        end else begin
            b_drv_o_r <= power_good_one; // see R14
            b_drv_oe_n_r <= drive_r[OUT_B_DRAIN_BIT] & power_good_one;
        end
    end

    // Third output level; its drive type is set elsewhere
    always_ff @(posedge clk) begin
        if (!nrst) begin
            c_out_r <= 1'b0;
        end else begin
            c_out_r <= level[2];
        end
    end

    assign aux_output_a_o = a_drv_o_r;
    assign aux_output_a_oe_n = a_drv_oe_n_r;
    assign aux_output_b_o = b_drv_o_r;
    assign aux_output_b_oe_n = b_drv_oe_n_r;
    assign aux_output_c = c_out_r;

    // ************************************************************
    // Checks
    // ************************************************************
    a_otp_default_load: assert property (@(posedge clk) // see R12
        disable iff (!nrst)
        !init_done_r |=> (delays_r[0] == $past(otp_delays_a) &&
                          drive_r == $past(otp_drive_control)))
        else $error("defaults were not loaded at init");
    a_write_after_init: assert property (@(posedge clk) // see R4
        disable iff (!nrst)
        (init_done_r && reg_we && reg_addr == OUT1_SEQUENCE_DELAYS_OFS)
        |=> delays_r[1] == $past(reg_wdata))
        else $error("delay register did not take the write");
    a_read_drive: assert property (@(posedge clk) // see R12
        disable iff (!nrst)
        (reg_re && reg_addr == OUT01_DRIVE_CONTROL_OFS)
        |=> (rvalid_r && rdata_r == $past(drive_r)))
        else $error("drive control read back wrong");
    a_push_pull_a: assert property (@(posedge clk) // see R10
        disable iff (!nrst)
        !drive_r[OUT_A_DRAIN_BIT] |=> (!a_drv_oe_n_r &&
                                       a_drv_o_r == $past(level[0])))
        else $error("push-pull first output not driven");
    a_open_drain_a: assert property (@(posedge clk) // see R10
        disable iff (!nrst)
        (drive_r[OUT_A_DRAIN_BIT] && level[0]) |=> a_drv_oe_n_r)
        else $error("open drain first output drove high");
    a_power_good_pass: assert property (@(posedge clk) // see R14
        disable iff (!nrst)
        !shared_pin_func_sel |=> b_drv_o_r == $past(power_good_one))
        else $error("shared pin did not carry power good");
    a_drain_b_any: assert property (@(posedge clk) // see R11
        disable iff (!nrst)
        !drive_r[OUT_B_DRAIN_BIT] |=> !b_drv_oe_n_r)
        else $error("push-pull shared pin released");
    a_gate_pin_one: assert property (@(posedge clk) // see R6
        disable iff (!nrst)
        (drive_r[OUT_A_GATE_MSB:OUT_A_GATE_LSB] == GATE_PIN_ONE &&
         !en_sync[0]) |-> !ctrl_a)
        else $error("first output not gated by enable pin one");
endmodule : aux_output_sequencer

// ==== verilog/aux_seq_pkg.sv ====
// Shared constants of the auxiliary output sequencer
package aux_seq_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OUT0_SEQUENCE_DELAYS_OFS = 8'h0C;
    localparam logic [7:0] OUT1_SEQUENCE_DELAYS_OFS = 8'h0D;
    localparam logic [7:0] OUT2_SEQUENCE_DELAYS_OFS = 8'h0E;
    localparam logic [7:0] OUT01_DRIVE_CONTROL_OFS = 8'h0F;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [7:0] DELAYS_RESET = 8'h00;
    localparam logic [7:0] DRIVE_CONTROL_RESET = 8'hAA;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int OFF_DELAY_MSB = 7;   // Shutdown code, upper nibble
    localparam int OFF_DELAY_LSB = 4;
    localparam int ON_DELAY_MSB = 3;    // Startup code, lower nibble
    localparam int ON_DELAY_LSB = 0;
    localparam int OUT_A_LEVEL_BIT = 0;
    localparam int OUT_A_GATE_LSB = 1;
    localparam int OUT_A_GATE_MSB = 2;
    localparam int OUT_A_DRAIN_BIT = 3;
    localparam int OUT_B_LEVEL_BIT = 4;
    localparam int OUT_B_GATE_LSB = 5;
    localparam int OUT_B_GATE_MSB = 6;
    localparam int OUT_B_DRAIN_BIT = 7;

    // ************************************************************
    // Gate selector codes
    // ************************************************************
    localparam logic [1:0] GATE_NONE = 2'h0;
    localparam logic [1:0] GATE_PIN_ONE = 2'h1;
    localparam logic [1:0] GATE_PIN_TWO = 2'h2;
    localparam logic [1:0] GATE_PIN_THREE = 2'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_FREQ_KHZ = 10000;    // 10 MHz system clock
    localparam int STEP_TIME_US = 500;      // One delay step, 0.5 ms
    localparam int HALF_MS_CYCLES = (STEP_TIME_US * CLK_FREQ_KHZ) / 1000;
    localparam int CNT_W = 18;              // Holds 15 ms of cycles
    localparam int CODE_W = 4;
endpackage : aux_seq_pkg

// ==== verilog/seq_if.sv ====
// Carrier between the sequencer top and one delay timer
`timescale 1ns/100ps
interface seq_if;
    import aux_seq_pkg::*;
    logic ctrl;                  // Control signal, gated for the first two outputs
    logic [CODE_W-1:0] on_code;  // Startup delay code
    logic [CODE_W-1:0] off_code; // Shutdown delay code
    logic on_long;               // Startup step is 1 ms
    logic off_long;              // Shutdown step is 1 ms
    logic level;                 // Delayed output level
    modport top (output ctrl, on_code, off_code, on_long, off_long,
                 input level);
    modport timer (input ctrl, on_code, off_code, on_long, off_long,
                   output level);
endinterface : seq_if

// ==== verilog/seq_timer.sv ====
// Startup and shutdown delay timer for one output
`timescale 1ns/100ps
module seq_timer
    import aux_seq_pkg::*;
#(
    parameter int STEP_CYCLES = HALF_MS_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    seq_if.timer sif
);
    // ************************************************************
    // Delay target
    // ************************************************************
    logic [CNT_W-1:0] cnt_r;      // Cycles since the control edge
    logic [CNT_W-1:0] step_c;     // Cycles per code step
    logic [CNT_W-1:0] target_c;   // Cycles until the output follows
    logic level_r;                // Delayed output level

    // Rising edge pending uses startup code, falling uses shutdown
    always_comb begin
        if (sif.ctrl) begin
            step_c = sif.on_long ? CNT_W'(2 * STEP_CYCLES)
                                 : CNT_W'(STEP_CYCLES); // see R3
            target_c = CNT_W'(sif.on_code * step_c); // see R2
        end else begin
            step_c = sif.off_long ? CNT_W'(2 * STEP_CYCLES)
                                  : CNT_W'(STEP_CYCLES); // see R16
            target_c = CNT_W'(sif.off_code * step_c); // see R1
        end
    end

    // ************************************************************
    // Counter and output
    // ************************************************************
    // Count while control differs from the output; cancel on return
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_r <= '0;
            level_r <= 1'b0;
        end else if (sif.ctrl == level_r) begin
            cnt_r <= '0; // see R15
        end else if (target_c == '0 || cnt_r >= target_c - 1'b1) begin
            cnt_r <= '0;
            level_r <= sif.ctrl; // see R1
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign sif.level = level_r;

    // ************************************************************
    // Checks
    // ************************************************************
    a_zero_code_now: assert property (@(posedge clk) // see R2
        disable iff (!nrst)
        (sif.ctrl != level_r && target_c == '0)
        |=> level_r == $past(sif.ctrl))
        else $error("zero delay code did not pass the edge at once");
    a_cancel_clears: assert property (@(posedge clk) // see R15
        disable iff (!nrst)
        (sif.ctrl == level_r) |=> (cnt_r == '0 && $stable(level_r)))
        else $error("returned control did not cancel the timer");
    a_follow_ctrl: assert property (@(posedge clk) // see R1
        disable iff (!nrst)
        $changed(level_r) |-> level_r == $past(sif.ctrl))
        else $error("output moved to a level control never asked for");
    a_not_early: assert property (@(posedge clk) // see R2
        disable iff (!nrst)
        $changed(level_r) |->
        ($past(target_c) == '0 ||
         $past(cnt_r) >= $past(target_c) - 1'b1))
        else $error("output changed before the delay ran out");
endmodule : seq_timer

// ==== tb/aux_load_model.sv ====
// Pad and pull-up model of the loads on the two drivable outputs
`timescale 1ns/100ps
module aux_load_model (
    input wire logic out_a,
    input wire logic oe_a_n,
    input wire logic out_b,
    input wire logic oe_b_n,
    output logic pad_a,
    output logic pad_b
);
    // A released pad is pulled high by the external pull-up
    assign pad_a = oe_a_n ? 1'h1 : out_a;
    assign pad_b = oe_b_n ? 1'h1 : out_b;
endmodule : aux_load_model

// ==== tb/tb_gpo_sequence_and_output_control.sv ====
// Self-checking bench of the auxiliary output sequencer
`timescale 1ns/100ps
module tb_gpo_sequence_and_output_control;
    import aux_seq_pkg::*;
    localparam int STEP = 4;              // Short step for simulation
    localparam logic [7:0] OTP_A = 8'h21; // Power-up defaults
    localparam logic [7:0] OTP_B = 8'h13;
    localparam logic [7:0] OTP_C = 8'h32;
    localparam logic [7:0] OTP_D = 8'h55;
    logic clk, nrst, we, re, sr, shr, fsel, pg, cc;
    logic [3:1] en;
    logic [7:0] addr, wdata, rdata;
    logic rvalid, ao, aoe_n, bo, boe_n, co, pa, pb;
    logic [1:0] pad_level;
    int fail_count, checked;

    aux_output_sequencer #(.STEP_CYCLES(STEP)) aux_output_sequencer_i (
        .clk(clk), .nrst(nrst), .reg_we(we), .reg_re(re),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .otp_delays_a(OTP_A), .otp_delays_b(OTP_B),
        .otp_delays_c(OTP_C), .otp_drive_control(OTP_D),
        .startup_range_sel(sr), .shutdown_range_sel(shr),
        .shared_pin_func_sel(fsel), .power_good_one(pg), .aux_c_ctrl(cc),
        .enable_pin_one(en[1]), .enable_pin_two(en[2]),
        .enable_pin_three(en[3]), .aux_output_a_i(pa),
        .aux_output_a_o(ao), .aux_output_a_oe_n(aoe_n),
        .aux_output_b_i(pb), .aux_output_b_o(bo),
        .aux_output_b_oe_n(boe_n), .aux_output_c(co),
        .pad_level(pad_level));

    aux_load_model aux_load_model_i (.out_a(ao), .oe_a_n(aoe_n),
        .out_b(bo), .oe_b_n(boe_n), .pad_a(pa), .pad_b(pb));

    // 10 MHz clock
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    // Compare one value and count it
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        we = 1'h1;
        addr = a;
        wdata = d;
        @(negedge clk);
        we = 1'h0;
    endtask : wr

    // Read strobe, answer one edge later
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        re = 1'h1;
        addr = a;
        @(negedge clk);
        re = 1'h0;
        // Answer stands from the edge after the strobe until the next
        check({7'h0, rvalid}, 8'h01);
        check(rdata, exp);
    endtask : rd_chk

    function automatic logic pin(input int w);
        return (w == 0) ? ao : ((w == 1) ? bo : co);
    endfunction : pin

    // Counts edges until output w reaches lvl; expects about n
    task automatic wait_out(input int w, input logic lvl, input int n);
        int k;
        k = 0;
        while (pin(w) !== lvl && k <= n + 3) begin
            @(negedge clk);
            k++;
        end
        check({7'h0, (k >= n - 1) && (k <= n + 3)}, 8'h01);
    endtask : wait_out

    // Defaults, write-back, unmapped places
    task automatic t_regs;
        rd_chk(OUT0_SEQUENCE_DELAYS_OFS, OTP_A);
        rd_chk(OUT1_SEQUENCE_DELAYS_OFS, OTP_B);
        rd_chk(OUT2_SEQUENCE_DELAYS_OFS, OTP_C);
        rd_chk(OUT01_DRIVE_CONTROL_OFS, OTP_D);
        wr(OUT2_SEQUENCE_DELAYS_OFS, 8'hA5);
        rd_chk(OUT2_SEQUENCE_DELAYS_OFS, 8'hA5);
        wr(8'h0B, 8'hFF);
        rd_chk(8'h10, 8'h00);
        rd_chk(OUT0_SEQUENCE_DELAYS_OFS, OTP_A);
    endtask : t_regs

    // Startup and shutdown delays of output a in both ranges
    task automatic t_delay_a;
        wr(OUT0_SEQUENCE_DELAYS_OFS, 8'h53);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h00);
        idle(30);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h01);
        wait_out(0, 1'h1, 3 * STEP);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h00);
        wait_out(0, 1'h0, 5 * STEP);
        sr = 1'h1;
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h01);
        wait_out(0, 1'h1, 6 * STEP);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h00);
        wait_out(0, 1'h0, 5 * STEP);
        shr = 1'h1;
        wr(OUT0_SEQUENCE_DELAYS_OFS, 8'hF0);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h01);
        wait_out(0, 1'h1, 0);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h00);
        wait_out(0, 1'h0, 30 * STEP);
        sr = 1'h0;
        shr = 1'h0;
    endtask : t_delay_a

    // Own delay registers of outputs b and c
    task automatic t_delay_bc;
        wr(OUT1_SEQUENCE_DELAYS_OFS, 8'h21);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h10);
        wait_out(1, 1'h1, STEP);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h00);
        wait_out(1, 1'h0, 2 * STEP);
        wr(OUT2_SEQUENCE_DELAYS_OFS, 8'h12);
        cc = 1'h1;
        wait_out(2, 1'h1, 2 * STEP);
        @(negedge clk);
        cc = 1'h0;
        wait_out(2, 1'h0, STEP);
    endtask : t_delay_bc

    // Each enable pin gates both outputs
    task automatic t_gating;
        wr(OUT0_SEQUENCE_DELAYS_OFS, 8'h00);
        wr(OUT1_SEQUENCE_DELAYS_OFS, 8'h00);
        for (int k = 1; k <= 3; k++) begin
            wr(OUT01_DRIVE_CONTROL_OFS, {1'h0, 2'(k), 2'h2, 2'(k), 1'h1});
            idle(6);
            check({6'h0, bo, ao}, 8'h00);
            en[k] = 1'h1;
            wait_out(0, 1'h1, 2);
            check({7'h0, bo}, 8'h01);
            @(negedge clk);
            en[k] = 1'h0;
            wait_out(0, 1'h0, 2);
        end
    endtask : t_gating

    // Push-pull and open-drain drive, shared pin in power good mode
    task automatic t_drive;
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h88);
        idle(4);
        check({6'h0, aoe_n, ao}, 8'h00);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h89);
        idle(8);
        check({5'h0, pad_level[0], aoe_n, ao}, 8'h07);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h01);
        idle(4);
        check({6'h0, aoe_n, ao}, 8'h01);
        fsel = 1'h0;
        pg = 1'h1;
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h90);
        idle(8);
        check({5'h0, pad_level[1], boe_n, bo}, 8'h07);
        pg = 1'h0;
        idle(4);
        check({6'h0, boe_n, bo}, 8'h00);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h00);
        pg = 1'h1;
        idle(4);
        check({6'h0, boe_n, bo}, 8'h01);
        pg = 1'h0;
        fsel = 1'h1;
    endtask : t_drive

    // Control falls back before the startup delay ends
    task automatic t_cancel;
        logic seen;
        wr(OUT0_SEQUENCE_DELAYS_OFS, 8'h08);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h01);
        idle(10);
        wr(OUT01_DRIVE_CONTROL_OFS, 8'h00);
        seen = 1'h0;
        repeat (40) begin
            @(negedge clk);
            seen = seen | ao;
        end
        check({7'h0, seen}, 8'h00);
    endtask : t_cancel

    // Verdict and end of run
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        fail_count = 0;
        checked = 0;
        nrst = 1'h0;
        we = 1'h0;
        re = 1'h0;
        addr = 8'h00;
        wdata = 8'h00;
        sr = 1'h0;
        shr = 1'h0;
        fsel = 1'h1;
        pg = 1'h0;
        cc = 1'h0;
        en = 3'h0;
        idle(20);
        nrst = 1'h1;
        idle(2);
        t_regs;
        t_delay_a;
        t_delay_bc;
        t_gating;
        t_drive;
        t_cancel;
        complete_run;
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        complete_run;
    end
endmodule : tb_gpo_sequence_and_output_control
